//--- logic/ccr_pkg.sv
package ccr_pkg;

  // ----------------------------------------------------------------
  // Register layout, fields numbered from the MSB:
  // field bit n sits at index [31-n]
  // ----------------------------------------------------------------
  localparam int          REG_W          = 32;
  localparam int          POS_ENABLE     = 31;
  localparam int          POS_PARITY     = 30;
  localparam int          POS_SIZE_HI    = 29;
  localparam int          POS_SIZE_LO    = 28;
  localparam int          POS_RATIO_HI   = 27;
  localparam int          POS_RATIO_LO   = 25;
  localparam int          POS_RAMT_HI    = 24;
  localparam int          POS_RAMT_LO    = 23;
  localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;
  localparam logic [31:0] WRITABLE_MASK  = 32'hff80_0000;

  // ----------------------------------------------------------------
  // Clock ratio codes, then L2 periods in half core cycles per code
  // ----------------------------------------------------------------
  localparam logic [2:0]  RATIO_OFF      = 3'h0;
  localparam logic [2:0]  RATIO_1        = 3'h1;
  localparam logic [2:0]  RATIO_1P5      = 3'h2;
  localparam logic [2:0]  RATIO_RSV0     = 3'h3;
  localparam logic [2:0]  RATIO_2        = 3'h4;
  localparam logic [2:0]  RATIO_2P5      = 3'h5;
  localparam logic [2:0]  RATIO_3        = 3'h6;
  localparam logic [2:0]  RATIO_RSV1     = 3'h7;
  localparam logic [2:0]  HALVES_1       = 3'h2;
  localparam logic [2:0]  HALVES_1P5     = 3'h3;
  localparam logic [2:0]  HALVES_2       = 3'h4;
  localparam logic [2:0]  HALVES_2P5     = 3'h5;
  localparam logic [2:0]  HALVES_3       = 3'h6;

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int          DATA_W         = 64;
  localparam int          PAR_W          = 8;
  localparam int          ADDR_W         = 17;

  typedef enum logic [1:0] {
    CCR_IDLE,
    CCR_ARMED,
    CCR_RUN
  } ccr_state_e;

  function automatic logic [2:0] ccr_halves(input logic [2:0] code);
    unique case (code)
      RATIO_1:   ccr_halves = HALVES_1;
      RATIO_1P5: ccr_halves = HALVES_1P5;
      RATIO_2:   ccr_halves = HALVES_2;
      RATIO_2P5: ccr_halves = HALVES_2P5;
      RATIO_3:   ccr_halves = HALVES_3;
      default:   ccr_halves = 3'h0;
    endcase
  endfunction : ccr_halves

endpackage : ccr_pkg

//--- logic/ccr_clkdiv.sv
module ccr_clkdiv
  import ccr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] ratio,
  output logic            l2_tick,
  output logic            l2_clk_en,
  output logic            dll_enable
);

  // ----------------------------------------------------------------
  // Divider on half-cycle credits
  // ----------------------------------------------------------------
  // Fractional ratios are averaged: a tick every halves/2 cycles.
  logic [3:0] acc_r;
  logic [2:0] halves;
  logic [3:0] acc_nxt;

  always_comb begin
    halves  = ccr_halves(ratio);
    acc_nxt = acc_r + 4'h2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r   <= 4'h0;
      l2_tick <= 1'b0;
    end else if (halves == 3'h0) begin
      acc_r   <= 4'h0;
      l2_tick <= 1'b0;
    end else if (acc_nxt >= {1'b0, halves}) begin
      acc_r   <= acc_nxt - {1'b0, halves};
      l2_tick <= 1'b1;
    end else begin
      acc_r   <= acc_nxt;
      l2_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      l2_clk_en  <= 1'b0;
      dll_enable <= 1'b0;
    end else begin
      l2_clk_en  <= (halves != 3'h0);
      dll_enable <= (ratio != RATIO_OFF);
    end
  end

  a_off_no_tick: assert property (@(posedge clk) disable iff (!rst_n)
    (ratio == RATIO_OFF) [*2] |-> !l2_tick)
    else $error("tick while clock ratio off");

  a_div1_ticks: assert property (@(posedge clk) disable iff (!rst_n)
    (ratio == RATIO_1) [*3] |-> l2_tick)
    else $error("divide by one missed a tick");

endmodule : ccr_clkdiv

//--- logic/ccr_control.sv
// Notes on behaviour
// - Register reachable only in supervisor mode.
// - Hard or power-on reset clears all.
// - Enable starts caching at next transaction.
// - Parity enable: generate writes, check reads.
// - Parity disabled drives parity bits zero.
// - Ratio field divides core clock.
// - Ratio 000 stops clock, disables DLL.
// - Nonzero ratio enables DLL; runs clock except reserved 011 and 111.
// - One address per access, never burst.
module ccr_control
  import ccr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              hard_reset_n,
  input  wire logic              supervisor,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   priv_fault,
  input  wire logic              txn_valid,
  input  wire logic              txn_write,
  input  wire logic [ADDR_W-1:0] txn_addr,
  input  wire logic [DATA_W-1:0] txn_wdata,
  output logic                   txn_ready,
  output logic                   txn_rvalid,
  output logic      [DATA_W-1:0] txn_rdata,
  output logic                   parity_error,
  output logic                   cache_active,
  output logic                   ram_sel,
  output logic                   ram_we,
  output logic      [ADDR_W-1:0] ram_addr,
  output logic      [DATA_W-1:0] ram_dout,
  output logic      [PAR_W-1:0]  ram_pout,
  input  wire logic [DATA_W-1:0] ram_din,
  input  wire logic [PAR_W-1:0]  ram_pin,
  output logic                   l2_tick,
  output logic                   l2_clk_en,
  output logic                   dll_enable
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic       rst_s1_r;
  logic       rst_n_r;
  logic       any_rst_n;

  assign any_rst_n = reset_n & hard_reset_n;

  always_ff @(posedge clk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [31:0] ctl_r;
  logic        wr_ok;
  logic        enable;
  logic        par_en;
  logic [2:0]  ratio;

  assign wr_ok  = reg_write & supervisor;
  assign enable = ctl_r[POS_ENABLE];
  assign par_en = ctl_r[POS_PARITY];
  assign ratio  = ctl_r[POS_RATIO_HI:POS_RATIO_LO];

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctl_r <= RESET_VALUE;
    end else if (wr_ok) begin
      ctl_r <= reg_wdata & WRITABLE_MASK;
    end
  end

  // Read data is masked by privilege so user code learns nothing
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata  <= 32'h0000_0000;
      priv_fault <= 1'b0;
    end else begin
      reg_rdata  <= (reg_read && supervisor) ? ctl_r : 32'h0000_0000;
      priv_fault <= (reg_read | reg_write) & ~supervisor;
    end
  end

  // ----------------------------------------------------------------
  // L2 clock generation
  // ----------------------------------------------------------------
  ccr_clkdiv u_div (
    .clk        (clk),
    .rst_n      (rst_n_r),
    .ratio      (ratio),
    .l2_tick    (l2_tick),
    .l2_clk_en  (l2_clk_en),
    .dll_enable (dll_enable)
  );

  // ----------------------------------------------------------------
  // Enable sequencing
  // ----------------------------------------------------------------
  // Enable takes effect on a transaction boundary, never mid-access.
  ccr_state_e state_r;

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= CCR_IDLE;
    end else begin
      unique case (state_r)
        CCR_IDLE:  if (enable) state_r <= CCR_ARMED;
        CCR_ARMED: begin
          if (!enable) state_r <= CCR_IDLE;
          else if (txn_valid && txn_ready) state_r <= CCR_RUN;
        end
        CCR_RUN:   if (!enable) state_r <= CCR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // RAM access, one address per beat
  // ----------------------------------------------------------------
  logic       active;
  logic       rd_pend_r;
  logic [7:0] gen_par;
  logic [7:0] chk_par;

  assign active       = (state_r == CCR_RUN) || (state_r == CCR_ARMED && txn_valid);
  assign cache_active = active;
  // Ready stays low from read strobe until data returns
  assign txn_ready    = enable & l2_clk_en & l2_tick & ~rd_pend_r & ~(ram_sel & ~ram_we);

  function automatic logic [7:0] ccr_parity(input logic [63:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < PAR_W; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction : ccr_parity

  assign gen_par = ccr_parity(txn_wdata);
  assign chk_par = ccr_parity(ram_din);

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ram_sel  <= 1'b0;
      ram_we   <= 1'b0;
      ram_addr <= '0;
      ram_dout <= '0;
      ram_pout <= '0;
    end else begin
      ram_sel <= txn_valid & txn_ready & active;
      ram_we  <= txn_valid & txn_ready & active & txn_write;
      if (txn_valid && txn_ready && active) begin
        ram_addr <= txn_addr;
        ram_dout <= txn_wdata;
        ram_pout <= par_en ? gen_par : 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_pend_r    <= 1'b0;
      txn_rvalid   <= 1'b0;
      txn_rdata    <= '0;
      parity_error <= 1'b0;
    end else begin
      rd_pend_r    <= ram_sel & ~ram_we;
      txn_rvalid   <= rd_pend_r;
      parity_error <= rd_pend_r & par_en & (chk_par != ram_pin);
      if (rd_pend_r) txn_rdata <= ram_din;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_write_taken;
    txn_valid && txn_ready && active && txn_write;
  endsequence

  a_reset_clears: assert property (@(posedge clk)
    !rst_n_r |-> ctl_r == 32'h0000_0000)
    else $error("register not cleared in reset");

  a_user_no_write: assert property (@(posedge clk) disable iff (!rst_n_r)
    reg_write && !supervisor |=> ctl_r == $past(ctl_r))
    else $error("user write changed register");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n_r)
    (ctl_r & ~WRITABLE_MASK) == 32'h0000_0000)
    else $error("reserved bits nonzero");

  a_idle_no_ram: assert property (@(posedge clk) disable iff (!rst_n_r)
    !enable [*2] |=> !ram_sel)
    else $error("RAM access while cache disabled");

  a_parity_zero: assert property (@(posedge clk) disable iff (!rst_n_r)
    s_write_taken ##0 !par_en |=> ram_pout == 8'h00)
    else $error("parity driven while disabled");

  a_parity_gen: assert property (@(posedge clk) disable iff (!rst_n_r)
    s_write_taken ##0 par_en |=> ram_pout == ccr_parity(ram_dout))
    else $error("write parity wrong");

  a_addr_each: assert property (@(posedge clk) disable iff (!rst_n_r)
    txn_valid && txn_ready && active |=> ram_sel && ram_addr == $past(txn_addr))
    else $error("access without own address");

  a_read_blocks: assert property (@(posedge clk) disable iff (!rst_n_r)
    (ram_sel && !ram_we) || rd_pend_r |-> !txn_ready)
    else $error("request taken while read pending");

  a_dll_follows: assert property (@(posedge clk) disable iff (!rst_n_r)
    ##1 dll_enable == ($past(ratio) != RATIO_OFF))
    else $error("DLL enable mismatch");

endmodule : ccr_control

//--- sim/ccr_sram_model.sv
module ccr_sram_model
  import ccr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              ram_sel,
  input  wire logic              ram_we,
  input  wire logic [ADDR_W-1:0] ram_addr,
  input  wire logic [DATA_W-1:0] ram_dout,
  input  wire logic [PAR_W-1:0]  ram_pout,
  input  wire logic              flip_par,
  output logic      [DATA_W-1:0] ram_din,
  output logic      [PAR_W-1:0]  ram_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // Word array, one address per access
  // ------------------------------------------------
  logic [DATA_W+PAR_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W+PAR_W-1:0] hold_r;
  logic [DATA_W+PAR_W-1:0] last_r = '0;
  logic                    hold_v_r = 1'b0;
  logic [DATA_W+PAR_W-1:0] flip;
  wire                     rd = ram_sel && !ram_we;
  assign flip = {{DATA_W{1'b0}}, {(PAR_W-1){1'b0}}, flip_par};
  always_ff @(posedge clk) begin
    if (ram_sel && ram_we)
      mem[ram_addr] <= {ram_dout, ram_pout};
    hold_v_r <= rd;
    if (rd)
      hold_r <= mem[ram_addr];
    // Idle bus toggles so stale data is never trusted
    last_r <= ~{ram_din, ram_pin};
  end
  // Pipelined part: data appears the cycle after the address
  assign {ram_din, ram_pin} = hold_v_r ? hold_r ^ flip : last_r;
endmodule : ccr_sram_model

//--- sim/l2_cache_control_register_bench.sv
module l2_cache_control_register_bench;
  import ccr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset_n = 0, hard_reset_n = 1, supervisor = 0, reg_write = 0, reg_read = 0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic priv_fault, txn_valid = 0, txn_write = 0, txn_ready, txn_rvalid, parity_error;
  logic [ADDR_W-1:0] txn_addr = '0, ram_addr;
  logic [DATA_W-1:0] txn_wdata = '0, txn_rdata, ram_dout, ram_din;
  logic cache_active, ram_sel, ram_we, l2_tick, l2_clk_en, dll_enable, flip_par = 0;
  logic [PAR_W-1:0] ram_pout, ram_pin;
  int err_total = 0, total_checks = 0, cyc = 0, n, e;
  logic [31:0] seed = 32'h0572f95a, v;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] d;
  ccr_control uut (.clk(clk), .reset_n(reset_n), .hard_reset_n(hard_reset_n), .supervisor(supervisor),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .priv_fault(priv_fault), .txn_valid(txn_valid), .txn_write(txn_write), .txn_addr(txn_addr),
    .txn_wdata(txn_wdata), .txn_ready(txn_ready), .txn_rvalid(txn_rvalid), .txn_rdata(txn_rdata),
    .parity_error(parity_error), .cache_active(cache_active), .ram_sel(ram_sel), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_dout(ram_dout), .ram_pout(ram_pout), .ram_din(ram_din),
    .ram_pin(ram_pin), .l2_tick(l2_tick), .l2_clk_en(l2_clk_en), .dll_enable(dll_enable));
  ccr_sram_model ram (.clk(clk), .ram_sel(ram_sel), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_dout(ram_dout), .ram_pout(ram_pout), .flip_par(flip_par), .ram_din(ram_din), .ram_pin(ram_pin));
  initial begin
    forever #5 clk = ~clk;
  end
  // ------------------------------------------------
  // Checking and closing
  // ------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Ceiling well above the little over a thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  function automatic logic [31:0] cfg(input logic en, input logic par, input logic [2:0] r);
    cfg = {en, par, 2'b11, r, 2'b10, 23'h0};
  endfunction : cfg
  function automatic int ticks(input logic [2:0] r);
    case (r)
      3'h1: ticks = 120;
      3'h2: ticks = 80;
      3'h4: ticks = 60;
      3'h5: ticks = 48;
      3'h6: ticks = 40;
      default: ticks = 0;
    endcase
  endfunction : ticks
  function automatic logic [7:0] par8(input logic [63:0] w);
    for (int i = 0; i < 8; i++) par8[i] = ^w[i*8 +: 8];
  endfunction : par8
  // ------------------------------------------------
  // Register and transaction tasks
  // ------------------------------------------------
  task automatic wr(input logic [31:0] val, input logic sup);
    @(negedge clk) {reg_write, supervisor, reg_wdata} = {1'b1, sup, val};
    @(negedge clk) reg_write = 0;
    chk(priv_fault, !sup);
  endtask : wr
  task automatic rd(input logic [31:0] exp);
    @(negedge clk) {reg_read, supervisor} = 2'b11;
    @(negedge clk) reg_read = 0;
    chk(reg_rdata, exp);
  endtask : rd
  task automatic tx(input logic we, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt,
                    input logic perr);
    int k;
    @(negedge clk) {txn_valid, txn_write, txn_addr, txn_wdata} = {1'b1, we, ad, dt};
    for (k = 0; k < 50 && txn_ready !== 1'b1; k++) @(negedge clk);
    @(negedge clk) txn_valid = 0;
    chk({ram_sel, ram_we, ram_addr}, {1'b1, we, ad});
    chk(cache_active, 1);
    if (we) chk(ram_dout, dt);
    if (we) chk(ram_pout, perr ? par8(dt) : 8'h00);
    for (k = 0; k < 8 && txn_rvalid !== 1'b1; k++) if (!we) @(negedge clk);
    if (!we) chk(txn_rvalid, 1);
    if (!we) chk(parity_error, perr);
    if (!we) chk(txn_rdata, dt);
  endtask : tx
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1;
    repeat (3) @(negedge clk);
    rd(32'h0);
    wr(32'hffff_ffff, 0);
    rd(32'h0);
    repeat (4) begin
      v = $random(seed);
      v[31] = 0;
      wr(v, 1);
      rd(v & WRITABLE_MASK);
    end
    @(negedge clk) {reg_read, supervisor} = 2'b10;
    @(negedge clk) reg_read = 0;
    chk({reg_rdata, priv_fault}, 33'h1);
    // Every ratio code, software holds enable low meanwhile
    for (int c = 0; c < 8; c++) begin
      wr(cfg(0, 0, c[2:0]), 1);
      repeat (4) @(negedge clk);
      n = 0;
      repeat (120) @(negedge clk) n += l2_tick;
      e = ticks(c[2:0]);
      chk((n + 1 >= e && n <= e + 1) ? e : n, e);
      chk(dll_enable, c != 0);
      if (c != 3 && c != 7) chk(l2_clk_en, e != 0);
    end
    @(negedge clk) txn_valid = 1;
    n = 0;
    repeat (10) @(negedge clk) n += ram_sel | txn_ready | cache_active;
    chk(n, 0);
    txn_valid = 0;
    // Ratio 2 runs the L2 clock at half the core clock
    wr(cfg(0, 0, 3'h4), 1);
    repeat (10) @(negedge clk);
    wr(cfg(1, 0, 3'h4), 1);
    for (int i = 0; i < 6; i++) begin
      a = $random(seed);
      d = {$random(seed), $random(seed)};
      tx(1, a, d, 0);
      tx(0, a, d, 0);
    end
    wr(cfg(1, 1, 3'h1), 1);
    a = $random(seed);
    d = {$random(seed), $random(seed)};
    tx(1, a, d, 1);
    tx(0, a, d, 0);
    flip_par = 1;
    tx(0, a, d, 1);
    flip_par = 0;
    @(negedge clk) hard_reset_n = 0;
    @(negedge clk) hard_reset_n = 1;
    repeat (3) @(negedge clk);
    rd(32'h0);
    chk(dll_enable, 0);
    test_done();
  end
endmodule : l2_cache_control_register_bench
